// ===== rtl/dtc_top.sv
// dual 16-bit timer/counter with special function register access
`timescale 1ns/10ps
`include "dtc_regs.svh"
module dtc_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // interrupt service entry and overflow flags
  input wire logic isr_enter_ch0,
  input wire logic isr_enter_ch1,
  output logic overflow_flag_ch0,
  output logic overflow_flag_ch1,
  // count and toggle pins
  input wire logic count_pin_ch0_in,
  output logic count_pin_ch0_out,
  output logic count_pin_ch0_oe_n,
  input wire logic count_pin_ch1_in,
  output logic count_pin_ch1_out,
  output logic count_pin_ch1_oe_n,
  // gate pins
  input wire logic gate_pin_ch0,
  input wire logic gate_pin_ch1
);
  import dtc_pkg::*;

  logic [7:0] timer_mode_config;
  logic [7:0] clock_control_reg;
  logic [7:0] pin_setting_toggle_enable;
  logic run_bit_ch0;
  logic run_bit_ch1;
  logic [3:0] div_count;
  logic toggle_ch0;
  logic toggle_ch1;
  logic [7:0] next_rdata;

  dtc_chan_if cif0 ();
  dtc_chan_if cif1 ();

  // address decode
  wire wr_tcon = sfr_wr & (sfr_addr == `DTC_ADDR_TCON);
  wire wr_timer_mode_config = sfr_wr & (sfr_addr == `DTC_ADDR_TIMER_MODE_CONFIG);
  wire wr_clock_control_reg = sfr_wr & (sfr_addr == `DTC_ADDR_CLOCK_CONTROL_REG);
  wire wr_p2s = sfr_wr & (sfr_addr == `DTC_ADDR_P2S);
  wire [7:0] tcon_read = {overflow_flag_ch1, run_bit_ch1, overflow_flag_ch0, run_bit_ch0, 4'h0};

  // mode fields and option bits
  wire dtc_mode_t mode_ch0 = dtc_mode_t'(timer_mode_config[1:0]);
  wire dtc_mode_t mode_ch1 = dtc_mode_t'(timer_mode_config[5:4]);
  wire src_ch0 = timer_mode_config[`DTC_TIMER_MODE_CONFIG_SRC0];
  wire src_ch1 = timer_mode_config[`DTC_TIMER_MODE_CONFIG_SRC1];
  wire clock_mode_ch0 = clock_control_reg[`DTC_CLOCK_CONTROL_REG_CM0];
  wire clock_mode_ch1 = clock_control_reg[`DTC_CLOCK_CONTROL_REG_CM1];
  wire toggle_enable_ch0 = pin_setting_toggle_enable[`DTC_P2S_TOG0];
  wire toggle_enable_ch1 = pin_setting_toggle_enable[`DTC_P2S_TOG1];
  wire tog_on_ch0 = wr_p2s & sfr_wdata[`DTC_P2S_TOG0] & ~toggle_enable_ch0;
  wire tog_on_ch1 = wr_p2s & sfr_wdata[`DTC_P2S_TOG1] & ~toggle_enable_ch1;

  // counting enables
  wire gate_ok_ch0 = ~timer_mode_config[`DTC_TIMER_MODE_CONFIG_GATE0] | gate_pin_ch0;
  wire gate_ok_ch1 = ~timer_mode_config[`DTC_TIMER_MODE_CONFIG_GATE1] | gate_pin_ch1;
  wire en_ch0 = run_bit_ch0 & gate_ok_ch0;
  wire en_ch1 = run_bit_ch1 & gate_ok_ch1 & (mode_ch1 != DTC_MODE_SPLIT);
  wire div_tick = (div_count == `DTC_DIV_LAST);

  // split-mode high byte runs as a timer off channel 1's run bit
  wire high_tick_ch0 = run_bit_ch1 & (mode_ch0 == DTC_MODE_SPLIT) & (clock_mode_ch0 | div_tick);
  wire ovf_ch1_any = cif1.ovf | cif0.ovf_high;

  // register byte selection
  assign cif0.mode = mode_ch0;
  assign cif1.mode = mode_ch1;
  assign cif0.tick_high = high_tick_ch0;
  assign cif1.tick_high = 1'b0;
  assign cif0.wdata = sfr_wdata;
  assign cif1.wdata = sfr_wdata;
  assign cif0.wr_low = sfr_wr & (sfr_addr == `DTC_ADDR_TL0);
  assign cif0.wr_high = sfr_wr & (sfr_addr == `DTC_ADDR_TH0);
  assign cif1.wr_low = sfr_wr & (sfr_addr == `DTC_ADDR_TL1);
  assign cif1.wr_high = sfr_wr & (sfr_addr == `DTC_ADDR_TH1);

  assign next_rdata = (sfr_addr == `DTC_ADDR_TCON) ? tcon_read :
                      (sfr_addr == `DTC_ADDR_TIMER_MODE_CONFIG) ? timer_mode_config :
                      (sfr_addr == `DTC_ADDR_TL0) ? cif0.count_low :
                      (sfr_addr == `DTC_ADDR_TL1) ? cif1.count_low :
                      (sfr_addr == `DTC_ADDR_TH0) ? cif0.count_high :
                      (sfr_addr == `DTC_ADDR_TH1) ? cif1.count_high :
                      (sfr_addr == `DTC_ADDR_CLOCK_CONTROL_REG) ? clock_control_reg :
                      (sfr_addr == `DTC_ADDR_P2S) ? pin_setting_toggle_enable : 8'h00;

  // shared pin: drive toggle level only while its enable is set
  assign count_pin_ch0_out = toggle_ch0;
  assign count_pin_ch1_out = toggle_ch1;
  assign count_pin_ch0_oe_n = ~toggle_enable_ch0;
  assign count_pin_ch1_oe_n = ~toggle_enable_ch1;

  dtc_tick_sel u_tick_ch0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .div_tick(div_tick),
    .clock_mode(clock_mode_ch0),
    .count_src(src_ch0),
    .enable(en_ch0),
    .count_pin(count_pin_ch0_in),
    .tick(cif0.tick_low)
  );

  dtc_tick_sel u_tick_ch1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .div_tick(div_tick),
    .clock_mode(clock_mode_ch1),
    .count_src(src_ch1),
    .enable(en_ch1),
    .count_pin(count_pin_ch1_in),
    .tick(cif1.tick_low)
  );

  dtc_chan u_chan0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .cif(cif0.chan)
  );

  dtc_chan u_chan1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .cif(cif1.chan)
  );

  // configuration registers and read data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_mode_config <= `DTC_RESET_BYTE;
      clock_control_reg <= `DTC_RESET_BYTE;
      pin_setting_toggle_enable <= `DTC_RESET_BYTE;
      run_bit_ch0 <= 1'b0;
      run_bit_ch1 <= 1'b0;
      sfr_rdata <= 8'h00;
    end
    else
    begin
      if (wr_timer_mode_config)
        timer_mode_config <= sfr_wdata;
      if (wr_clock_control_reg)
        clock_control_reg <= sfr_wdata & `DTC_CLOCK_CONTROL_REG_MASK;
      if (wr_p2s)
        pin_setting_toggle_enable <= sfr_wdata & `DTC_P2S_MASK;
      if (wr_tcon)
      begin
        run_bit_ch0 <= sfr_wdata[`DTC_TCON_TR0];
        run_bit_ch1 <= sfr_wdata[`DTC_TCON_TR1];
      end
      if (sfr_rd)
        sfr_rdata <= next_rdata;
    end
  end

  // overflow flags: hardware set wins over any clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      overflow_flag_ch0 <= 1'b0;
      overflow_flag_ch1 <= 1'b0;
    end
    else
    begin
      if (cif0.ovf)
        overflow_flag_ch0 <= 1'b1;
      else if (wr_tcon)
        overflow_flag_ch0 <= sfr_wdata[`DTC_TCON_TF0];
      else if (isr_enter_ch0)
        overflow_flag_ch0 <= 1'b0;
      if (ovf_ch1_any)
        overflow_flag_ch1 <= 1'b1;
      else if (wr_tcon)
        overflow_flag_ch1 <= sfr_wdata[`DTC_TCON_TF1];
      else if (isr_enter_ch1)
        overflow_flag_ch1 <= 1'b0;
    end
  end

  // prescaler and toggle outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_count <= 4'h0;
      toggle_ch0 <= 1'b1;
      toggle_ch1 <= 1'b1;
    end
    else
    begin
      div_count <= div_tick ? 4'h0 : div_count + 4'h1;
      if (tog_on_ch0)
        toggle_ch0 <= 1'b1;
      else if (cif0.ovf && toggle_enable_ch0)
        toggle_ch0 <= ~toggle_ch0;
      if (tog_on_ch1)
        toggle_ch1 <= 1'b1;
      else if (cif1.ovf && toggle_enable_ch1)
        toggle_ch1 <= ~toggle_ch1;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire no_wr_ch0 = ~cif0.wr_low & ~cif0.wr_high;
  wire [15:0] cnt16_ch0 = {cif0.count_high, cif0.count_low};

  property p_ovf_flag;
    cif0.ovf |=> overflow_flag_ch0;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

  property p_isr_clear;
    isr_enter_ch0 && !cif0.ovf && !wr_tcon |=> !overflow_flag_ch0;
  endproperty
  a_isr_clear: assert property (p_isr_clear) else $error("service entry did not clear flag");

  property p_run_hold;
    !run_bit_ch0 && !cif0.wr_low |=> $stable(cif0.count_low);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("count moved while stopped");

  property p_gate_hold;
    timer_mode_config[`DTC_TIMER_MODE_CONFIG_GATE0] && !gate_pin_ch0 && !cif0.wr_low |=> $stable(cif0.count_low);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate low");

  property p_toggle_inv;
    cif0.ovf && toggle_enable_ch0 && !wr_p2s |=> count_pin_ch0_out != $past(count_pin_ch0_out);
  endproperty
  a_toggle_inv: assert property (p_toggle_inv) else $error("toggle output not inverted");

  property p_toggle_start;
    tog_on_ch0 |=> count_pin_ch0_out && !count_pin_ch0_oe_n;
  endproperty
  a_toggle_start: assert property (p_toggle_start) else $error("toggle output not high on enable");

  // reference count of twelve, free running from reset like the prescaler
  logic [3:0] div_gap;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_gap <= 4'h0;
    end
    else
    begin
      div_gap <= (div_gap == 4'hb) ? 4'h0 : div_gap + 4'h1;
    end
  end

  property p_div12;
    div_tick == (div_gap == 4'hb);
  endproperty
  a_div12: assert property (p_div12) else $error("prescaler period not twelve");

  property p_ch1_halt;
    mode_ch1 == DTC_MODE_SPLIT && !cif1.wr_low && !cif1.wr_high |=> $stable(cif1.count_low) && $stable(cif1.count_high);
  endproperty
  a_ch1_halt: assert property (p_ch1_halt) else $error("channel 1 counted in mode 3");

  property p_inc16;
    cif0.tick_low && mode_ch0 == DTC_MODE_16 && no_wr_ch0 |=> cnt16_ch0 == $past(cnt16_ch0) + 16'h0001;
  endproperty
  a_inc16: assert property (p_inc16) else $error("16-bit count not incremented by one");

  property p_edge_count;
    en_ch0 && src_ch0 && $past(count_pin_ch0_in) && !count_pin_ch0_in |-> cif0.tick_low;
  endproperty
  a_edge_count: assert property (p_edge_count) else $error("falling pin edge not counted");

  property p_wrap13;
    cif0.ovf && mode_ch0 == DTC_MODE_13 && no_wr_ch0 |=> cif0.count_high == 8'h00 && cif0.count_low[4:0] == 5'h00;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit count did not wrap to zero");

  c_ovf_ch0: cover property (cif0.ovf && mode_ch0 == DTC_MODE_16);
  c_reload: cover property (cif0.ovf && mode_ch0 == DTC_MODE_RELOAD);
  c_split_high: cover property (cif0.ovf_high);
  c_toggle: cover property (cif1.ovf && toggle_enable_ch1);
endmodule : dtc_top

// ===== rtl/dtc_regs.svh
// register addresses, field positions, reset values and counts of the dual timer
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

`define DTC_ADDR_TCON 8'h88
`define DTC_ADDR_TIMER_MODE_CONFIG 8'h89
`define DTC_ADDR_TL0 8'h8a
`define DTC_ADDR_TL1 8'h8b
`define DTC_ADDR_TH0 8'h8c
`define DTC_ADDR_TH1 8'h8d
`define DTC_ADDR_CLOCK_CONTROL_REG 8'h8e
`define DTC_ADDR_P2S 8'hb5

`define DTC_TIMER_MODE_CONFIG_GATE1 7
`define DTC_TIMER_MODE_CONFIG_SRC1 6
`define DTC_TIMER_MODE_CONFIG_GATE0 3
`define DTC_TIMER_MODE_CONFIG_SRC0 2

`define DTC_TCON_TF1 7
`define DTC_TCON_TR1 6
`define DTC_TCON_TF0 5
`define DTC_TCON_TR0 4

`define DTC_CLOCK_CONTROL_REG_CM1 4
`define DTC_CLOCK_CONTROL_REG_CM0 3
`define DTC_CLOCK_CONTROL_REG_MASK 8'h18

`define DTC_P2S_TOG1 3
`define DTC_P2S_TOG0 2
`define DTC_P2S_MASK 8'h8d

`define DTC_RESET_BYTE 8'h00
`define DTC_DIV_LAST 4'hb

`endif

// ===== rtl/dtc_pkg.sv
// types shared by the dual timer modules
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_MODE_13,
    DTC_MODE_16,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

endpackage : dtc_pkg

// ===== rtl/dtc_chan_if.sv
// control and count signals between the timer top and one counting channel
`timescale 1ns/10ps
interface dtc_chan_if;
  import dtc_pkg::*;
  dtc_mode_t mode;
  logic tick_low;
  logic tick_high;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic ovf;
  logic ovf_high;

  modport ctrl (
    output mode, tick_low, tick_high, wr_low, wr_high, wdata,
    input count_low, count_high, ovf, ovf_high
  );
  modport chan (
    input mode, tick_low, tick_high, wr_low, wr_high, wdata,
    output count_low, count_high, ovf, ovf_high
  );
endinterface : dtc_chan_if

// ===== rtl/dtc_tick_sel.sv
// per-channel count source: prescaled tick, raw clock or falling pin edge
`timescale 1ns/10ps
module dtc_tick_sel (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // selection
  input wire logic div_tick,
  input wire logic clock_mode,
  input wire logic count_src,
  input wire logic enable,
  // pin and result
  input wire logic count_pin,
  output logic tick
);
  logic pin_q;
  logic pin_fall;
  logic timer_tick;

  // reset low so a low pin at release is not taken as an edge
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_q <= 1'b0;
    end
    else
    begin
      pin_q <= count_pin;
    end
  end

  assign pin_fall = pin_q & ~count_pin;
  assign timer_tick = clock_mode ? 1'b1 : div_tick;
  assign tick = enable & (count_src ? pin_fall : timer_tick);
endmodule : dtc_tick_sel

// ===== rtl/dtc_chan.sv
// one 16-bit count register with 13-bit, 16-bit, reload and split modes
`timescale 1ns/10ps
module dtc_chan (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control and counts
  dtc_chan_if.chan cif
);
  import dtc_pkg::*;

  logic [7:0] count_low;
  logic [7:0] count_high;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic [12:0] sum13;
  logic [15:0] sum16;
  logic full;

  assign sum13 = {count_high, count_low[4:0]} + 13'h0001;
  assign sum16 = {count_high, count_low} + 16'h0001;
  assign full = (cif.mode == DTC_MODE_13) ? (&count_high & &count_low[4:0]) :
                (cif.mode == DTC_MODE_16) ? (&count_high & &count_low) : &count_low;
  assign cif.ovf = cif.tick_low & full;
  assign cif.ovf_high = cif.tick_high & (cif.mode == DTC_MODE_SPLIT) & &count_high;
  assign cif.count_low = count_low;
  assign cif.count_high = count_high;

  always_comb
  begin
    next_low = count_low;
    next_high = count_high;
    if (cif.tick_low)
    begin
      case (cif.mode)
        DTC_MODE_13:
        begin
          next_high = sum13[12:5];
          next_low = {count_low[7:5], sum13[4:0]};
        end
        DTC_MODE_16:
        begin
          next_high = sum16[15:8];
          next_low = sum16[7:0];
        end
        DTC_MODE_RELOAD:
        begin
          next_low = full ? count_high : count_low + 8'h01;
        end
        DTC_MODE_SPLIT:
        begin
          next_low = count_low + 8'h01;
        end
        default:
        begin
          next_low = count_low;
        end
      endcase
    end
    if (cif.tick_high && cif.mode == DTC_MODE_SPLIT)
    begin
      next_high = count_high + 8'h01;
    end
    if (cif.wr_low)
    begin
      next_low = cif.wdata;
    end
    if (cif.wr_high)
    begin
      next_high = cif.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_low <= 8'h00;
      count_high <= 8'h00;
    end
    else
    begin
      count_low <= next_low;
      count_high <= next_high;
    end
  end
endmodule : dtc_chan

// ===== verif/dtc_pin_model.sv
// far-side model of the count pins: external pulse source sharing the toggle outputs
`timescale 1ns/10ps
module dtc_pin_model (
  // clock
  input wire logic clk,
  // device pin drivers
  input wire logic out_ch0,
  input wire logic oe_n_ch0,
  input wire logic out_ch1,
  input wire logic oe_n_ch1,
  // resolved pin levels
  output logic pin_ch0,
  output logic pin_ch1
);
  logic drv_ch0 = 1'b1;
  logic drv_ch1 = 1'b1;
  // source lets go of the pin while the device owns it
  assign pin_ch0 = oe_n_ch0 ? drv_ch0 : out_ch0;
  assign pin_ch1 = oe_n_ch1 ? drv_ch1 : out_ch1;
  // n falling edges, each level held w cycles
  task automatic pulses(input int n, input int w, input bit ch);
    repeat (n)
    begin
      @(posedge clk);
      if (ch)
        drv_ch1 <= 1'b0;
      else
        drv_ch0 <= 1'b0;
      repeat (w) @(posedge clk);
      if (ch)
        drv_ch1 <= 1'b1;
      else
        drv_ch0 <= 1'b1;
      repeat (w - 1) @(posedge clk);
    end
  endtask : pulses
endmodule : dtc_pin_model

// ===== verif/tb_top.sv
// self-checking bench for the dual timer
`timescale 1ns/10ps
`include "dtc_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
  logic clk, sys_rst, sfr_wr, sfr_rd, isr0, isr1, gate0, gate1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic flag0, flag1, out0, oe0, out1, oe1, pin0, pin1;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  dtc_top uut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .isr_enter_ch0(isr0),
    .isr_enter_ch1(isr1), .overflow_flag_ch0(flag0), .overflow_flag_ch1(flag1),
    .count_pin_ch0_in(pin0), .count_pin_ch0_out(out0), .count_pin_ch0_oe_n(oe0),
    .count_pin_ch1_in(pin1), .count_pin_ch1_out(out1), .count_pin_ch1_oe_n(oe1),
    .gate_pin_ch0(gate0), .gate_pin_ch1(gate1));
  dtc_pin_model pins (.clk(clk), .out_ch0(out0), .oe_n_ch0(oe0), .out_ch1(out1),
    .oe_n_ch1(oe1), .pin_ch0(pin0), .pin_ch1(pin1));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    `CHK(sfr_rdata, e)
  endtask : rdchk
  // run for k+2 ticks, then stop with flag bits kept
  task automatic run(input logic [7:0] v, input int k, input logic [7:0] stop, input logic [1:0] fl);
    wr(`DTC_ADDR_TCON, v);
    repeat (k) @(posedge clk);
    #1;
    `CHK({flag1, flag0}, fl)
    wr(`DTC_ADDR_TCON, stop);
    #1;
  endtask : run
  task automatic load0(input logic [7:0] md, input logic [7:0] ck, input logic [7:0] h, input logic [7:0] l);
    wr(`DTC_ADDR_TIMER_MODE_CONFIG, md);
    wr(`DTC_ADDR_CLOCK_CONTROL_REG, ck);
    wr(`DTC_ADDR_TH0, h);
    wr(`DTC_ADDR_TL0, l);
  endtask : load0
  task automatic t_regs();
    logic [7:0] a[8];
    a = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'hb5};
    `CHK({out0, oe0, out1, oe1, flag0, flag1}, 6'h3c)
    foreach (a[i]) rdchk(a[i], 8'h00);
    wr(`DTC_ADDR_CLOCK_CONTROL_REG, 8'hff);
    rdchk(`DTC_ADDR_CLOCK_CONTROL_REG, 8'h18);
    wr(`DTC_ADDR_P2S, 8'h81);
    rdchk(`DTC_ADDR_P2S, 8'h81);
    wr(`DTC_ADDR_TIMER_MODE_CONFIG, 8'ha5);
    rdchk(`DTC_ADDR_TIMER_MODE_CONFIG, 8'ha5);
    wr(`DTC_ADDR_TCON, 8'h0f);
    rdchk(`DTC_ADDR_TCON, 8'h00);
    wr(8'h90, 8'hff);
    rdchk(8'h90, 8'h00);
    wr(`DTC_ADDR_P2S, 8'h00);
  endtask : t_regs
  task automatic t_mode16();
    load0(8'h01, 8'h08, 8'hff, 8'hf0);
    run(8'h10, 18, 8'h20, 2'b01);
    `CHK(flag0, 1'b1)
    rdchk(`DTC_ADDR_TL0, 8'h04);
    rdchk(`DTC_ADDR_TH0, 8'h00);
    @(posedge clk);
    isr0 <= 1'b1;
    @(posedge clk);
    isr0 <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(flag0, 1'b0)
    wr(`DTC_ADDR_TCON, 8'h20);
    #1;
    `CHK(flag0, 1'b1)
    wr(`DTC_ADDR_TCON, 8'h00);
  endtask : t_mode16
  task automatic t_mode13();
    load0(8'h00, 8'h08, 8'hff, 8'hfe);
    run(8'h10, 2, 8'h20, 2'b01);
    `CHK(flag0, 1'b1)
    rdchk(`DTC_ADDR_TL0, 8'he2);
    rdchk(`DTC_ADDR_TH0, 8'h00);
    wr(`DTC_ADDR_TCON, 8'h00);
  endtask : t_mode13
  task automatic t_presc();
    load0(8'h01, 8'h00, 8'h00, 8'h00);
    run(8'h10, 118, 8'h00, 2'b00);
    rdchk(`DTC_ADDR_TL0, 8'h0a);
  endtask : t_presc
  task automatic t_counter();
    load0(8'h05, 8'h08, 8'h00, 8'h00);
    wr(`DTC_ADDR_TCON, 8'h10);
    pins.pulses(5, 1, 1'b0);
    repeat (3) @(posedge clk);
    wr(`DTC_ADDR_TCON, 8'h00);
    rdchk(`DTC_ADDR_TL0, 8'h05);
    wr(`DTC_ADDR_TIMER_MODE_CONFIG, 8'h0d);
    wr(`DTC_ADDR_TCON, 8'h10);
    pins.pulses(3, 2, 1'b0);
    gate0 <= 1'b1;
    pins.pulses(3, 2, 1'b0);
    repeat (3) @(posedge clk);
    wr(`DTC_ADDR_TCON, 8'h00);
    rdchk(`DTC_ADDR_TL0, 8'h08);
    gate0 <= 1'b0;
  endtask : t_counter
  // channel 1 counter function, gated by its own gate pin
  task automatic t_counter1();
    wr(`DTC_ADDR_TIMER_MODE_CONFIG, 8'hd0);
    wr(`DTC_ADDR_TCON, 8'h40);
    pins.pulses(4, 1, 1'b1);
    repeat (3) @(posedge clk);
    wr(`DTC_ADDR_TCON, 8'h00);
    rdchk(`DTC_ADDR_TL1, 8'h04);
    gate1 <= 1'b0;
    wr(`DTC_ADDR_TCON, 8'h40);
    pins.pulses(2, 1, 1'b1);
    repeat (3) @(posedge clk);
    wr(`DTC_ADDR_TCON, 8'h00);
    rdchk(`DTC_ADDR_TL1, 8'h04);
    gate1 <= 1'b1;
  endtask : t_counter1
  task automatic t_chan1();
    wr(`DTC_ADDR_TIMER_MODE_CONFIG, 8'h20);
    wr(`DTC_ADDR_CLOCK_CONTROL_REG, 8'h10);
    wr(`DTC_ADDR_TH1, 8'hf0);
    wr(`DTC_ADDR_TL1, 8'hfe);
    wr(`DTC_ADDR_P2S, 8'h08);
    #1;
    `CHK({out1, oe1}, 2'b10)
    run(8'h40, 2, 8'h80, 2'b10);
    repeat (2) @(posedge clk);
    #1;
    `CHK({flag1, out1}, 2'b10)
    rdchk(`DTC_ADDR_TL1, 8'hf2);
    rdchk(`DTC_ADDR_TH1, 8'hf0);
    @(posedge clk);
    isr1 <= 1'b1;
    @(posedge clk);
    isr1 <= 1'b0;
    #1;
    `CHK(flag1, 1'b0)
    wr(`DTC_ADDR_TIMER_MODE_CONFIG, 8'h30);
    run(8'h40, 10, 8'h00, 2'b00);
    rdchk(`DTC_ADDR_TL1, 8'hf2);
    wr(`DTC_ADDR_P2S, 8'h00);
  endtask : t_chan1
  task automatic t_split();
    load0(8'h03, 8'h08, 8'hfe, 8'hfe);
    run(8'h50, 2, 8'ha0, 2'b11);
    `CHK({flag0, flag1}, 2'b11)
    rdchk(`DTC_ADDR_TL0, 8'h02);
    rdchk(`DTC_ADDR_TH0, 8'h02);
    wr(`DTC_ADDR_TCON, 8'h00);
  endtask : t_split
  task automatic t_toggle();
    load0(8'h02, 8'h08, 8'hfe, 8'hfe);
    wr(`DTC_ADDR_P2S, 8'h04);
    #1;
    `CHK({out0, oe0, pin0}, 3'b101)
    run(8'h10, 8, 8'h00, 2'b01);
    repeat (2) @(posedge clk);
    #1;
    `CHK({out0, pin0}, 2'b00)
    wr(`DTC_ADDR_P2S, 8'h00);
    #1;
    `CHK(oe0, 1'b1)
    wr(`DTC_ADDR_P2S, 8'h04);
    #1;
    `CHK(out0, 1'b1)
    wr(`DTC_ADDR_P2S, 8'h00);
  endtask : t_toggle
  initial
  begin
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    {sfr_wr, sfr_rd, isr0, isr1, gate0, gate1} = 6'h00;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    gate1 <= 1'b1;
    @(posedge clk);
    #1;
    t_regs();
    t_mode16();
    t_mode13();
    t_presc();
    t_counter();
    t_counter1();
    t_chan1();
    t_split();
    t_toggle();
    tally_and_finish();
  end
endmodule : tb_top
